// File: rtl/rfd_framer.sv
module rfd_framer (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic tx_start,
	input wire logic [1:0] tx_kind,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	input wire logic tx_byte_last,
	input wire logic tx_false_token,
	output logic tx_byte_taken_ff,
	output logic tx_busy_ff,
	output logic tx_done_ff,
	output logic tx_aborted_ff,
	input wire logic [1:0] line_rx_sym,
	output logic [1:0] line_tx_sym_ff,
	input wire logic rx_copy,
	output logic [7:0] rx_byte_ff,
	output logic rx_byte_valid_ff,
	output logic rx_frame_done_ff,
	output logic rx_abort_ff,
	output logic [31:0] rx_status_ff
);
	logic rst_s1_ff;
	logic rst_n_ff;
	logic [1:0] rx_s1_ff;
	logic [1:0] rx_s2_ff;
	rfd_pkg::rfd_tx_state_t tx_state_ff;
	rfd_pkg::rfd_tx_state_t nxt_tx_state;
	rfd_pkg::rfd_rx_state_t rx_state_ff;
	logic tx_last_ff;
	logic nxt_tx_last;
	logic tx_fs_ff;
	logic abort_req_ff;
	logic ser_load;
	logic [15:0] ser_data;
	logic [1:0] ser_sym;
	logic ser_busy;
	logic ser_last;
	logic take;
	logic tx_end;
	logic abort_now;
	logic [15:0] win_ff;
	logic [15:0] nxt_win;
	logic [2:0] rx_cnt_ff;
	logic rx_cv_seen_ff;
	logic byte_edge;
	logic is_ed;
	logic mark_edi;

	function automatic logic [15:0] byte_syms(input logic [7:0] b);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < rfd_pkg::BYTE_W; i++) begin
			s[2 * i +: 2] = {1'b0, b[i]};
		end
		return s;
	endfunction

	function automatic logic [7:0] syms_byte(input logic [15:0] s);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < rfd_pkg::BYTE_W; i++) begin
			b[i] = s[2 * i];
		end
		return b;
	endfunction

	function automatic logic syms_cv(input logic [15:0] s);
		logic v;
		v = 1'b0;
		for (int i = 0; i < rfd_pkg::BYTE_W; i++) begin
			v = v | s[2 * i + 1];
		end
		return v;
	endfunction

	// Reset release through two stages
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// Ring input comes from the medium, not this clock
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rx_s1_ff <= rfd_pkg::SYM_ZERO;
			rx_s2_ff <= rfd_pkg::SYM_ZERO;
		end else if (ce) begin
			rx_s1_ff <= line_rx_sym;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	rfd_sym_ser u_ser (
		.clk(clk),
		.rst_n(rst_n_ff),
		.ce(ce),
		.load(ser_load),
		.data(ser_data),
		.sym(ser_sym),
		.busy(ser_busy),
		.last(ser_last)
	);

	// Transmit sequencing; new byte loads on the last symbol, so delimiters stay byte aligned
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_last = tx_last_ff;
		ser_load = 1'b0;
		ser_data = rfd_pkg::SD_SYMS;
		take = 1'b0;
		tx_end = 1'b0;
		abort_now = 1'b0;
		unique case (tx_state_ff)
			rfd_pkg::TX_IDLE: begin
				if (tx_start) begin
					ser_load = 1'b1;
					nxt_tx_last = 1'b0;
					nxt_tx_state = (tx_kind == rfd_pkg::KIND_ABORT) ? rfd_pkg::TX_ASD
						: rfd_pkg::TX_SD;
				end
			end
			rfd_pkg::TX_SD, rfd_pkg::TX_BODY: begin
				if (ser_last) begin
					ser_load = 1'b1;
					if (abort_req_ff || (!tx_last_ff && !tx_byte_valid)) begin
						abort_now = 1'b1;
						nxt_tx_state = rfd_pkg::TX_ASD;
					end else if (tx_last_ff) begin
						ser_data = rfd_pkg::ED_SYMS;
						nxt_tx_state = rfd_pkg::TX_ED;
					end else begin
						ser_data = byte_syms(tx_byte);
						take = 1'b1;
						nxt_tx_last = tx_byte_last;
						nxt_tx_state = rfd_pkg::TX_BODY;
					end
				end
			end
			rfd_pkg::TX_ASD: begin
				if (ser_last) begin
					ser_load = 1'b1;
					ser_data = rfd_pkg::ED_SYMS;
					nxt_tx_state = rfd_pkg::TX_ED;
				end
			end
			rfd_pkg::TX_ED: begin
				if (ser_last) begin
					if (tx_fs_ff) begin
						ser_load = 1'b1;
						ser_data = byte_syms(rfd_pkg::FS_BYTE);
						nxt_tx_state = rfd_pkg::TX_FS;
					end else begin
						tx_end = 1'b1;
						nxt_tx_state = rfd_pkg::TX_IDLE;
					end
				end
			end
			rfd_pkg::TX_FS: begin
				if (ser_last) begin
					tx_end = 1'b1;
					nxt_tx_state = rfd_pkg::TX_IDLE;
				end
			end
			default: begin
				nxt_tx_state = rfd_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tx_state_ff <= rfd_pkg::TX_IDLE;
			tx_last_ff <= 1'b0;
			tx_fs_ff <= 1'b0;
		end else if (ce) begin
			tx_state_ff <= nxt_tx_state;
			tx_last_ff <= nxt_tx_last;
			if (tx_state_ff == rfd_pkg::TX_IDLE && tx_start) begin
				tx_fs_ff <= (tx_kind == rfd_pkg::KIND_FRAME) || (tx_kind == rfd_pkg::KIND_IMMED);
			end else if (abort_now) begin
				tx_fs_ff <= 1'b0;
			end
		end
	end

	// False token is only known after capture, so it is held until a byte edge
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			abort_req_ff <= 1'b0;
		end else if (ce) begin
			if (tx_false_token && (tx_state_ff == rfd_pkg::TX_SD
				|| tx_state_ff == rfd_pkg::TX_BODY)) begin
				abort_req_ff <= 1'b1;
			end else if (tx_state_ff == rfd_pkg::TX_IDLE) begin
				abort_req_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tx_byte_taken_ff <= 1'b0;
			tx_busy_ff <= 1'b0;
			tx_done_ff <= 1'b0;
			tx_aborted_ff <= 1'b0;
		end else if (ce) begin
			tx_byte_taken_ff <= take;
			tx_busy_ff <= (nxt_tx_state != rfd_pkg::TX_IDLE);
			tx_done_ff <= tx_end;
			tx_aborted_ff <= abort_now;
		end
	end

	// Own symbols while sending, else repeat the ring with the window as delay
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			line_tx_sym_ff <= rfd_pkg::SYM_ZERO;
		end else if (ce) begin
			line_tx_sym_ff <= ser_busy ? ser_sym : win_ff[15:14];
		end
	end

	// Receive window, newest symbol at the bottom
	assign byte_edge = (rx_state_ff != rfd_pkg::RX_HUNT) && (rx_cnt_ff == rfd_pkg::CNT_LAST);
	assign is_ed = ((win_ff & rfd_pkg::ED_MASK) == rfd_pkg::ED_SYMS);
	assign mark_edi = byte_edge && is_ed && (rx_state_ff == rfd_pkg::RX_BODY)
		&& rx_copy && rx_cv_seen_ff;

	always_comb begin
		nxt_win = {win_ff[13:0], rx_s2_ff};
		if (mark_edi) begin
			nxt_win[rfd_pkg::EDI_REPEAT_POS] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			win_ff <= 16'h0000;
		end else if (ce) begin
			win_ff <= nxt_win;
		end
	end

	// Alignment is taken only from a start delimiter seen while hunting
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rx_state_ff <= rfd_pkg::RX_HUNT;
			rx_cnt_ff <= 3'h0;
		end else if (ce) begin
			unique case (rx_state_ff)
				rfd_pkg::RX_HUNT: begin
					if (win_ff == rfd_pkg::SD_SYMS) begin
						rx_state_ff <= rfd_pkg::RX_FIRST;
						rx_cnt_ff <= 3'h0;
					end
				end
				rfd_pkg::RX_FIRST, rfd_pkg::RX_BODY: begin
					rx_cnt_ff <= rx_cnt_ff + rfd_pkg::CNT_ONE;
					if (byte_edge) begin
						rx_state_ff <= is_ed ? rfd_pkg::RX_HUNT : rfd_pkg::RX_BODY;
					end
				end
				default: begin
					rx_state_ff <= rfd_pkg::RX_HUNT;
				end
			endcase
		end
	end

	// Cleared in every hunting cycle, which cannot coincide with a set
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rx_cv_seen_ff <= 1'b0;
		end else if (ce) begin
			if (byte_edge && !is_ed && syms_cv(win_ff)) begin
				rx_cv_seen_ff <= 1'b1;
			end else if (rx_state_ff == rfd_pkg::RX_HUNT) begin
				rx_cv_seen_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rx_byte_ff <= 8'h00;
			rx_byte_valid_ff <= 1'b0;
			rx_frame_done_ff <= 1'b0;
			rx_abort_ff <= 1'b0;
			rx_status_ff <= rfd_pkg::STAT_RESET;
		end else if (ce) begin
			rx_byte_valid_ff <= byte_edge && !is_ed && !syms_cv(win_ff);
			rx_abort_ff <= byte_edge && is_ed && (rx_state_ff == rfd_pkg::RX_FIRST);
			rx_frame_done_ff <= byte_edge && is_ed && (rx_state_ff == rfd_pkg::RX_BODY);
			if (byte_edge && !is_ed) begin
				rx_byte_ff <= syms_byte(win_ff);
			end
			if (byte_edge && is_ed && (rx_state_ff == rfd_pkg::RX_BODY)) begin
				rx_status_ff <= rfd_pkg::STAT_RESET;
				rx_status_ff[rfd_pkg::STAT_LOCAL_ERR] <= rx_copy && rx_cv_seen_ff;
				rx_status_ff[rfd_pkg::STAT_REMOTE_ERR] <= win_ff[0];
			end
		end
	end

	a_done_needs_ed: assert property (@(posedge clk) disable iff (!rst_n_ff)
		$rose(rx_frame_done_ff) |-> $past(ce && is_ed && rx_state_ff == rfd_pkg::RX_BODY))
		else $error("frame done without end delimiter");

	a_ed_byte_aligned: assert property (@(posedge clk) disable iff (!rst_n_ff)
		$rose(rx_frame_done_ff) |-> $past(rx_cnt_ff) == rfd_pkg::CNT_LAST)
		else $error("end delimiter accepted off byte boundary");

	a_local_err_bit: assert property (@(posedge clk) disable iff (!rst_n_ff)
		$rose(rx_frame_done_ff) |->
		rx_status_ff[rfd_pkg::STAT_LOCAL_ERR] == $past(rx_copy && rx_cv_seen_ff))
		else $error("local error bit wrong");

	a_remote_err_bit: assert property (@(posedge clk) disable iff (!rst_n_ff)
		$rose(rx_frame_done_ff) |-> rx_status_ff[rfd_pkg::STAT_REMOTE_ERR] == $past(win_ff[0]))
		else $error("remote error bit wrong");

	a_abort_is_sd_ed: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ce && tx_state_ff == rfd_pkg::TX_ASD && ser_last) |=>
		tx_state_ff == rfd_pkg::TX_ED && ser_sym == rfd_pkg::SYM_CV1)
		else $error("abort not closed by end delimiter");

	a_underrun_abort: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ce && tx_state_ff inside {rfd_pkg::TX_SD, rfd_pkg::TX_BODY} && ser_last
		&& !tx_last_ff && !tx_byte_valid)
		|=> tx_state_ff == rfd_pkg::TX_ASD && tx_aborted_ff)
		else $error("underrun did not abort");

	a_start_sends_sd: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ce && tx_state_ff == rfd_pkg::TX_IDLE && tx_start) |=>
		ser_busy && ser_sym == rfd_pkg::SYM_CV1 ##1 ser_sym == rfd_pkg::SYM_CV0 || !ce)
		else $error("start delimiter not sent");

	a_ed_on_boundary: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(tx_state_ff == rfd_pkg::TX_ED && $past(tx_state_ff) != rfd_pkg::TX_ED)
		|-> $past(ser_last && ce))
		else $error("end delimiter not byte aligned");

	a_msb_first: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(ce && ser_load) |=> ser_sym == $past(ser_data[15:14]))
		else $error("first symbol is not the top bit");

	a_fs_after_ed: assert property (@(posedge clk) disable iff (!rst_n_ff)
		(tx_state_ff == rfd_pkg::TX_FS) |-> $past(tx_state_ff) inside {rfd_pkg::TX_ED,
		rfd_pkg::TX_FS})
		else $error("status byte not after end delimiter");
endmodule // rfd_framer

// File: rtl/rfd_pkg.sv
// Behaviour
// - Bytes go on and off the ring MSB first
// - Start delimiter opens frames, tokens, aborts; sets alignment
// - Abort is start delimiter then end delimiter
// - End delimiter valid only on bit/byte boundary
// - Frame reported received only after valid end delimiter
// - Normal transmission ends with byte-aligned end delimiter
// - Start delimiter on token release and immediate transmit
// - Abort on false free token or transmit underrun
// - Delimiter symbol patterns with violations at 0,1,3,4
// - Copied frame violation sets edi and status bit 29
// - Received edi already set gives status bit 28
package rfd_pkg;
	// Line symbol: {violation, value}
	localparam logic [1:0] SYM_ZERO = 2'h0;
	localparam logic [1:0] SYM_ONE = 2'h1;
	localparam logic [1:0] SYM_CV0 = 2'h2;
	localparam logic [1:0] SYM_CV1 = 2'h3;
	localparam int SYM_W = 2;
	localparam int BYTE_W = 8;
	localparam int SYMS_W = SYM_W * BYTE_W;
	// Delimiters, first symbol in the top two bits
	localparam logic [15:0] SD_SYMS = 16'hE380;
	localparam logic [15:0] ED_SYMS = 16'hE790;
	localparam logic [15:0] ED_MASK = 16'hFFFE;
	localparam logic [15:0] EDI_SYM_BIT = 16'h0001;
	localparam int EDI_REPEAT_POS = 2;
	localparam logic [7:0] FS_BYTE = 8'h00;
	localparam logic [2:0] CNT_LAST = 3'h7;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam int STAT_LOCAL_ERR = 29;
	localparam int STAT_REMOTE_ERR = 28;
	localparam logic [31:0] STAT_RESET = 32'h00000000;
	localparam logic [1:0] KIND_FRAME = 2'h0;
	localparam logic [1:0] KIND_TOKEN = 2'h1;
	localparam logic [1:0] KIND_IMMED = 2'h2;
	localparam logic [1:0] KIND_ABORT = 2'h3;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_SD = 3'h1,
		TX_BODY = 3'h3,
		TX_ED = 3'h2,
		TX_FS = 3'h6,
		TX_ASD = 3'h7
	} rfd_tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT = 2'h0,
		RX_FIRST = 2'h1,
		RX_BODY = 2'h3
	} rfd_rx_state_t;
endpackage

// File: rtl/rfd_sym_ser.sv
module rfd_sym_ser (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [15:0] data,
	output logic [1:0] sym,
	output logic busy,
	output logic last
);
	logic [15:0] shreg_ff;
	logic [2:0] cnt_ff;
	logic busy_ff;

	// First symbol of the byte leaves first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg_ff <= 16'h0000;
			cnt_ff <= 3'h0;
			busy_ff <= 1'b0;
		end else if (ce) begin
			if (load) begin
				shreg_ff <= data;
				cnt_ff <= 3'h0;
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				shreg_ff <= {shreg_ff[13:0], rfd_pkg::SYM_ZERO};
				cnt_ff <= cnt_ff + rfd_pkg::CNT_ONE;
				busy_ff <= (cnt_ff != rfd_pkg::CNT_LAST);
			end
		end
	end

	assign sym = shreg_ff[15:14];
	assign busy = busy_ff;
	assign last = busy_ff && (cnt_ff == rfd_pkg::CNT_LAST);
endmodule // rfd_sym_ser

// File: tb/rfd_ring_model.sv
module rfd_ring_model (
	input wire logic clk,
	input wire logic [1:0] line_tx_sym,
	output logic [1:0] line_rx_sym
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cap_q[$];
	logic cap_on;
	initial begin
		line_rx_sym = rfd_pkg::SYM_ZERO;
		cap_on = 1'b0;
	end
	// Recording the whole window lets the bench find the delimiter itself
	always @(posedge clk) begin
		if (cap_on) begin
			cap_q.push_back(line_tx_sym);
		end
	end
	// Eight symbols, first in the top bits; ring is never left floating
	task automatic send_syms(input logic [15:0] s);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			#1;
			line_rx_sym = s[2*i+:2];
		end
	endtask
endmodule // rfd_ring_model

// File: tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, ce, tx_start, tx_byte_valid, tx_byte_last, tx_false_token, rx_copy;
	logic [1:0] tx_kind, line_rx_sym, line_tx_sym_ff;
	logic [7:0] tx_byte, rx_byte_ff;
	logic tx_byte_taken_ff, tx_busy_ff, tx_done_ff, tx_aborted_ff;
	logic rx_byte_valid_ff, rx_frame_done_ff, rx_abort_ff;
	logic [31:0] rx_status_ff, last_status;
	int err_count, checks, seed, n_done, n_abort, n_txab;
	logic [7:0] got_q[$], tx_q[$], exp_b[$];
	logic [1:0] exp_q[$];

	rfd_framer dut (.clk(clk), .rstn(rstn), .ce(ce), .tx_start(tx_start), .tx_kind(tx_kind),
		.tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_byte_last(tx_byte_last),
		.tx_false_token(tx_false_token), .tx_byte_taken_ff(tx_byte_taken_ff),
		.tx_busy_ff(tx_busy_ff), .tx_done_ff(tx_done_ff), .tx_aborted_ff(tx_aborted_ff),
		.line_rx_sym(line_rx_sym), .line_tx_sym_ff(line_tx_sym_ff), .rx_copy(rx_copy),
		.rx_byte_ff(rx_byte_ff), .rx_byte_valid_ff(rx_byte_valid_ff),
		.rx_frame_done_ff(rx_frame_done_ff), .rx_abort_ff(rx_abort_ff),
		.rx_status_ff(rx_status_ff));
	rfd_ring_model rm (.clk(clk), .line_tx_sym(line_tx_sym_ff), .line_rx_sym(line_rx_sym));

	always #10 clk = ~clk;

	always @(posedge clk) begin
		if (rx_byte_valid_ff === 1'b1) got_q.push_back(rx_byte_ff);
		if (rx_frame_done_ff === 1'b1) begin
			n_done++;
			last_status = rx_status_ff;
		end
		if (rx_abort_ff === 1'b1) n_abort++;
		if (tx_aborted_ff === 1'b1) n_txab++;
		if (tx_byte_taken_ff === 1'b1) begin
			#1;
			void'(tx_q.pop_front());
			present();
		end
	end

	task automatic present();
		tx_byte_valid = tx_q.size() > 0;
		tx_byte = (tx_q.size() > 0) ? tx_q[0] : 8'h00;
		tx_byte_last = tx_q.size() == 1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] b2s(input logic [7:0] b);
		logic [15:0] s;
		for (int i = 0; i < 8; i++) s[2*i+:2] = {1'b0, b[i]};
		return s;
	endfunction

	task automatic push16(input logic [15:0] s);
		for (int i = 7; i >= 0; i--) exp_q.push_back(s[2*i+:2]);
	endtask

	task automatic run_tx(input logic [1:0] kind, input int nb, input int ft_at, input string name);
		int k;
		int ab0;
		logic ab;
		logic [7:0] b;
		ab = (ft_at > 0) || (nb == 0 && kind != 2'h3);
		exp_q.delete();
		rm.cap_q.delete();
		ab0 = n_txab;
		push16(rfd_pkg::SD_SYMS);
		for (int i = 0; i < nb; i++) begin
			b = 8'($random(seed));
			tx_q.push_back(b);
			if (!(ft_at > 0 && i > 0)) push16(b2s(b));
		end
		// An abort closes a started sequence with a fresh start delimiter and end delimiter
		if (ab) push16(rfd_pkg::SD_SYMS);
		push16(rfd_pkg::ED_SYMS);
		if (!ab && (kind == 2'h0 || kind == 2'h2)) push16(16'h0000);
		present();
		@(posedge clk);
		#1;
		tx_kind = kind;
		tx_start = 1'b1;
		rm.cap_on = 1'b1;
		@(posedge clk);
		#1;
		tx_start = 1'b0;
		if (ft_at > 0) begin
			repeat (ft_at) @(posedge clk);
			#1;
			tx_false_token = 1'b1;
			@(posedge clk);
			#1;
			tx_false_token = 1'b0;
		end
		for (k = 0; k < 400 && tx_done_ff !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		check(32'(k < 400), 32'h1);
		repeat (4) @(posedge clk);
		#1;
		rm.cap_on = 1'b0;
		check(tx_busy_ff, 32'h0);
		if (kind != 2'h3) check(32'(n_txab - ab0), 32'(ab));
		for (k = 0; k < rm.cap_q.size() && rm.cap_q[k][1] !== 1'b1; k++);
		for (int i = 0; i < exp_q.size(); i++) begin
			check(rm.cap_q[k+i], exp_q[i]);
		end
		tx_q.delete();
		present();
		$display("test %s done", name);
	endtask

	task automatic run_rx(input int nb, input logic cv, input logic edi, input logic copy,
		input string name);
		int n0;
		int a0;
		int k;
		int m;
		logic [7:0] b;
		rx_copy = copy;
		rm.cap_q.delete();
		rm.cap_on = 1'b1;
		n0 = n_done;
		a0 = n_abort;
		got_q.delete();
		exp_b.delete();
		rm.send_syms(rfd_pkg::SD_SYMS);
		for (int i = 0; i < nb; i++) begin
			b = 8'($random(seed));
			if (cv && i == 1) begin
				rm.send_syms(16'hAAAA);
			end else begin
				exp_b.push_back(b);
				rm.send_syms(b2s(b));
			end
		end
		rm.send_syms(rfd_pkg::ED_SYMS | (edi ? rfd_pkg::EDI_SYM_BIT : 16'h0000));
		rm.send_syms(16'h0000);
		rm.send_syms(16'h0000);
		rm.cap_on = 1'b0;
		m = 0;
		for (k = 0; k < rm.cap_q.size() && m < 3; k++) begin
			if (rm.cap_q[k] === rfd_pkg::SYM_CV1) m++;
		end
		// Third cv1 on the repeat path opens the end delimiter; its last symbol is the indicator
		check(rm.cap_q[k + 6], {1'b0, edi | (cv & copy)});
		check(32'(n_abort - a0), 32'(nb == 0));
		check(32'(n_done - n0), 32'(nb > 0));
		check(32'(got_q.size()), 32'(exp_b.size()));
		for (int i = 0; i < exp_b.size(); i++) check(got_q[i], exp_b[i]);
		if (nb > 0) check(last_status, {2'h0, cv & copy, edi, 28'h0});
		$display("test %s done", name);
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial begin
		int n0;
		int k;
		logic [1:0] s0;
		clk = 1'b0;
		rstn = 1'b0;
		ce = 1'b1;
		seed = 94;
		tx_start = 1'b0;
		tx_kind = 2'h0;
		tx_false_token = 1'b0;
		rx_copy = 1'b0;
		present();
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (4) @(posedge clk);
		run_tx(2'h1, 1, 0, "token");
		run_tx(2'h0, 3, 0, "frame");
		run_tx(2'h2, 2, 0, "immediate");
		run_tx(2'h3, 0, 0, "abort");
		run_tx(2'h0, 0, 0, "underrun");
		run_tx(2'h0, 3, 10, "false_token");
		// Clock enable low must hold the abort sequence where it stands
		@(posedge clk);
		#1;
		tx_kind = 2'h3;
		tx_start = 1'b1;
		@(posedge clk);
		#1;
		tx_start = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		s0 = line_tx_sym_ff;
		ce = 1'b0;
		repeat (5) begin
			@(posedge clk);
			#1;
			check(line_tx_sym_ff, s0);
			check(tx_busy_ff, 32'h1);
		end
		ce = 1'b1;
		for (k = 0; k < 40 && tx_done_ff !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		// Sixteen symbols in all, three already sent before the freeze
		check(32'(k), 32'hD);
		$display("test ce_freeze done");
		repeat (30) @(posedge clk);
		run_rx(2, 1'b0, 1'b0, 1'b1, "rx_plain");
		run_rx(3, 1'b1, 1'b0, 1'b1, "rx_cv_copy");
		run_rx(3, 1'b1, 1'b0, 1'b0, "rx_cv_nocopy");
		run_rx(2, 1'b0, 1'b1, 1'b0, "rx_edi");
		run_rx(0, 1'b0, 1'b0, 1'b0, "rx_abort");
		// Misaligned end delimiter must not close the frame
		n0 = n_done;
		rm.send_syms(rfd_pkg::SD_SYMS);
		rm.send_syms(b2s(8'h5A));
		rm.send_syms(16'h0000 | {8'h00, rfd_pkg::ED_SYMS[15:8]});
		rm.send_syms({rfd_pkg::ED_SYMS[7:0], 8'h00});
		rm.send_syms(16'h0000);
		check(32'(n_done - n0), 32'h0);
		rm.send_syms(rfd_pkg::ED_SYMS);
		rm.send_syms(16'h0000);
		rm.send_syms(16'h0000);
		check(32'(n_done - n0), 32'h1);
		$display("test rx_misaligned done");
		print_verdict();
	end
endmodule // tb_top
